// [hdl/ccs_defines.vh]
// Purpose: constants of the cpu/peripheral clock select block
// Assumes: 8-bit register port, byte offsets
// Notes:   definitions only
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH

// register offsets
`define CCS_OFS_OSC_MODE    8'h00
`define CCS_OFS_MAIN_OSC    8'h01
`define CCS_OFS_MAIN_MODE   8'h02
`define CCS_OFS_PROC_CLK    8'h03
`define CCS_OFS_INT_OSC     8'h04
`define CCS_OFS_STAB_STAT   8'h05

// oscillator mode register fields
`define CCS_B_MAIN_EXT      7
`define CCS_B_MAIN_OSC_EN   6
`define CCS_B_SUB_EXT       5
`define CCS_B_SUB_OSC_EN    4
`define CCS_B_AMP_GAIN      0
// main osc control register
`define CCS_B_MAIN_STOP     7
// main clock mode register
`define CCS_B_MAIN_SRC_SEL  2
`define CCS_B_MAIN_STAT     1
`define CCS_B_CPU_MAIN_SEL  0
// processor clock control register
`define CCS_B_CPU_ON_SUB    5
`define CCS_B_CPU_SUB_SEL   4
// internal osc mode register
`define CCS_B_LOW_STOP      1
// stabilization status register
`define CCS_B_STAB_DONE     0

// reset values
`define CCS_RST_OSC_MODE    8'h00
`define CCS_RST_MAIN_STOP   1'b1
`define CCS_RST_MAIN_MODE   2'h0
`define CCS_RST_CPU_SUB     1'b0
`define CCS_RST_LOW_STOP    1'b0

// clock mux source indices
`define CCS_SRC_HI_OSC      2'h0
`define CCS_SRC_HI_SYS      2'h1
`define CCS_SRC_SUB         2'h2
`define CCS_SRC_NONE        2'h3

`endif

// [hdl/ccs_clk_switch.v]
// Purpose: glitch-free clock multiplexer on sampled clock levels
// Assumes: source levels are sampled in the reference clock domain
// Notes:   source moves only while old and new levels are both low
`timescale 1ns/1ps
`default_nettype none

module ccs_clk_switch #(
    parameter N = 4
) (
    // clock and reset
    input  wire         i_ref_clk,
    input  wire         i_rst_n,
    // sources and selection
    input  wire [N-1:0] i_src,
    input  wire [1:0]   i_sel,
    // switched clock and active source
    output reg          o_clk,
    output reg  [1:0]   o_cur
);

    reg  [1:0] cur_nxt;

    // change source only with both clocks at a low level
    always @*
    begin
        cur_nxt = o_cur;
        if ((i_sel != o_cur) && !i_src[o_cur] && !i_src[i_sel])
            cur_nxt = i_sel;                       // R19
    end

    // registered output, low on the switching cycle
    always @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_cur <= 2'h0;
            o_clk <= 1'b0;
        end
        else
        begin
            o_cur <= cur_nxt;
            o_clk <= (cur_nxt == o_cur) ? i_src[o_cur] : 1'b0; // R19
        end
    end

endmodule // ccs_clk_switch

`default_nettype wire

// [hdl/ccs_clock_select.v]
// Purpose: cpu and peripheral clock source control
// Assumes: oscillator levels arrive synchronous to i_ref_clk
// Notes:   registers on a plain port, read data one cycle later
//
// Behaviour
// (R1) status flags: sub-flag, then main-flag decode source
// (R2) sub enable clear stops crystal and external
// (R3) software leaves subsystem before clearing its enable
// (R4) stop mode never halts subsystem oscillator
// (R5) low-speed clock never drives the cpu
// (R6) option chooses low-speed osc stoppable or not
// (R7) low-speed osc runs after reset, feeds watchdog
// (R8) stop bit 1 halts, 0 restarts low-speed
// (R9) non-stoppable option ignores low-speed stop bit
// (R10) main select 0: peripheral from internal osc
// (R11) main select 1: peripheral X1 or external
// (R12) oscillator mode bits 7..4 and 0; stop bit 7
// (R13) main select bit 2, cpu main bit 0, sub bit 4
// (R14) reset: cpu and peripheral on internal osc
// (R15) software order to reach high-speed system clock
// (R16) gain bit 1 at 10 MHz or more
// (R17) poll stabilization only for crystal main clock
// (R18) software order to reach subsystem clock
// (R19) clock switch without truncated pulses
// (R20) no sub selection changes while sub runs
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_defines.vh"

module ccs_clock_select #(
    parameter AW = 8,
    parameter DW = 8
) (
    // clock and reset
    input  wire          i_ref_clk,
    input  wire          i_nrst,
    // register port
    input  wire [AW-1:0] i_addr,
    input  wire [DW-1:0] i_wdata,
    input  wire          i_wr,
    input  wire          i_rd,
    output reg  [DW-1:0] o_rdata,
    // option settings and mode inputs
    input  wire          i_lowspeed_nostop_opt,
    input  wire          i_wdt_enable_opt,
    input  wire          i_tmh1_low_sel,
    input  wire          i_stop_mode,
    input  wire          i_main_stab_done,
    // oscillator levels
    input  wire          i_hi_osc_clk,
    input  wire          i_x1_clk,
    input  wire          i_ext_main_clk,
    input  wire          i_sub_xtal_clk,
    input  wire          i_ext_sub_clk,
    input  wire          i_low_osc_clk,
    // oscillator controls
    output reg           o_x1_osc_run,
    output reg           o_ext_main_accept,
    output reg           o_amp_gain_high,
    output reg           o_sub_xtal_run,
    output reg           o_ext_sub_accept,
    output reg           o_low_osc_run,
    // switched clocks
    output wire          o_cpu_clk,
    output wire          o_periph_clk,
    output reg           o_wdt_clk,
    output reg           o_tmh1_clk,
    // cpu clock status
    output reg           o_cpu_on_sub_flag,
    output reg           o_main_source_status_flag
);

    // reset synchroniser
    reg          rst_meta_r;
    reg          rst_sync_r;

    // software-written control bits
    reg          main_external_input_select_r;
    reg          main_osc_enable_r;
    reg          sub_external_input_select_r;
    reg          sub_osc_enable_r;
    reg          amplifier_gain_select_r;
    reg          main_osc_stop_r;
    reg          main_source_select_r;
    reg          cpu_main_clock_select_r;
    reg          cpu_subsystem_select_r;
    reg          lowspeed_osc_stop_r;

    // option caught after reset release
    reg          opt_taken_r;
    reg          lowspeed_nostop_r;

    // read path
    reg [DW-1:0] rdata_nxt;

    // derived clocks and selections
    reg          hi_sys_clk;
    reg          sub_clk;
    reg          low_run;
    reg [1:0]    cpu_sel;
    reg [1:0]    per_sel;
    wire [3:0]   src_lvls;
    wire [1:0]   cpu_cur;
    wire [1:0]   per_cur;

    // release reset through two flip-flops
    always @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // register writes; reset leaves everything on internal osc
    always @(posedge i_ref_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            main_external_input_select_r <= 1'b0;  // R14
            main_osc_enable_r            <= 1'b0;
            sub_external_input_select_r  <= 1'b0;
            sub_osc_enable_r             <= 1'b0;
            amplifier_gain_select_r      <= 1'b0;
            main_osc_stop_r              <= `CCS_RST_MAIN_STOP;
            main_source_select_r         <= 1'b0;  // R14
            cpu_main_clock_select_r      <= 1'b0;
            cpu_subsystem_select_r       <= `CCS_RST_CPU_SUB;
            lowspeed_osc_stop_r          <= `CCS_RST_LOW_STOP; // R7
        end
        else if (i_wr)
        begin
            case (i_addr)
                `CCS_OFS_OSC_MODE:
                begin
                    // R12
                    main_external_input_select_r <=
                        i_wdata[`CCS_B_MAIN_EXT];
                    main_osc_enable_r <= i_wdata[`CCS_B_MAIN_OSC_EN];
                    sub_external_input_select_r <=
                        i_wdata[`CCS_B_SUB_EXT];
                    sub_osc_enable_r <= i_wdata[`CCS_B_SUB_OSC_EN];
                    amplifier_gain_select_r <=
                        i_wdata[`CCS_B_AMP_GAIN];
                end
                `CCS_OFS_MAIN_OSC:
                    main_osc_stop_r <= i_wdata[`CCS_B_MAIN_STOP]; // R12
                `CCS_OFS_MAIN_MODE:
                begin
                    // R13
                    main_source_select_r <=
                        i_wdata[`CCS_B_MAIN_SRC_SEL];
                    cpu_main_clock_select_r <=
                        i_wdata[`CCS_B_CPU_MAIN_SEL];
                end
                `CCS_OFS_PROC_CLK:
                    cpu_subsystem_select_r <=
                        i_wdata[`CCS_B_CPU_SUB_SEL];      // R13
                `CCS_OFS_INT_OSC:
                    lowspeed_osc_stop_r <=
                        i_wdata[`CCS_B_LOW_STOP];         // R8
                default:
                    lowspeed_osc_stop_r <= lowspeed_osc_stop_r;
            endcase
        end
    end

    // take the nonvolatile option once, right after release
    always @(posedge i_ref_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            opt_taken_r       <= 1'b0;
            lowspeed_nostop_r <= 1'b1;
        end
        else if (!opt_taken_r)
        begin
            opt_taken_r       <= 1'b1;
            lowspeed_nostop_r <= i_lowspeed_nostop_opt; // R6
        end
    end

    // read mux; unmapped offsets read zero
    always @*
    begin
        rdata_nxt = {DW{1'b0}};
        case (i_addr)
            `CCS_OFS_OSC_MODE:
            begin
                rdata_nxt[`CCS_B_MAIN_EXT] =
                    main_external_input_select_r;
                rdata_nxt[`CCS_B_MAIN_OSC_EN] = main_osc_enable_r;
                rdata_nxt[`CCS_B_SUB_EXT] =
                    sub_external_input_select_r;
                rdata_nxt[`CCS_B_SUB_OSC_EN] = sub_osc_enable_r;
                rdata_nxt[`CCS_B_AMP_GAIN] = amplifier_gain_select_r;
            end
            `CCS_OFS_MAIN_OSC:
                rdata_nxt[`CCS_B_MAIN_STOP] = main_osc_stop_r;
            `CCS_OFS_MAIN_MODE:
            begin
                rdata_nxt[`CCS_B_MAIN_SRC_SEL] = main_source_select_r;
                rdata_nxt[`CCS_B_MAIN_STAT] = o_main_source_status_flag;
                rdata_nxt[`CCS_B_CPU_MAIN_SEL] =
                    cpu_main_clock_select_r;
            end
            `CCS_OFS_PROC_CLK:
            begin
                rdata_nxt[`CCS_B_CPU_ON_SUB] = o_cpu_on_sub_flag;
                rdata_nxt[`CCS_B_CPU_SUB_SEL] = cpu_subsystem_select_r;
            end
            `CCS_OFS_INT_OSC:
                rdata_nxt[`CCS_B_LOW_STOP] = lowspeed_osc_stop_r;
            `CCS_OFS_STAB_STAT:
                rdata_nxt[`CCS_B_STAB_DONE] = i_main_stab_done; // R17
            default:
                rdata_nxt = {DW{1'b0}};
        endcase
    end

    // read data stand one cycle after the strobe only
    always @(posedge i_ref_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            o_rdata <= {DW{1'b0}};
        else if (i_rd)
            o_rdata <= rdata_nxt;
        else
            o_rdata <= {DW{1'b0}};
    end

    // source clocks and mux selections
    always @*
    begin
        // high-speed system clock: X1 or external main
        if (!main_osc_enable_r || main_osc_stop_r)
            hi_sys_clk = 1'b0;
        else if (main_external_input_select_r)
            hi_sys_clk = i_ext_main_clk;               // R11
        else
            hi_sys_clk = i_x1_clk;                     // R11
        // subsystem clock; enable clear kills both kinds, stop mode
        // plays no part here
        if (!sub_osc_enable_r)
            sub_clk = 1'b0;                            // R2 R4
        else if (sub_external_input_select_r)
            sub_clk = i_ext_sub_clk;
        else
            sub_clk = i_sub_xtal_clk;
        // peripheral source
        per_sel = main_source_select_r ? `CCS_SRC_HI_SYS
                                       : `CCS_SRC_HI_OSC; // R10 R11
        // cpu source; low-speed osc is not an input of this mux
        if (cpu_subsystem_select_r)
            cpu_sel = `CCS_SRC_SUB;                    // R10 R5
        else if (main_source_select_r && cpu_main_clock_select_r)
            cpu_sel = `CCS_SRC_HI_SYS;                 // R11
        else
            cpu_sel = `CCS_SRC_HI_OSC;                 // R10 R14
        // low-speed osc: option may forbid stopping it
        low_run = lowspeed_nostop_r || !lowspeed_osc_stop_r; // R8 R9
    end

    // source levels in mux index order
    assign src_lvls = {1'b0, sub_clk, hi_sys_clk, i_hi_osc_clk};

    // cpu clock switch
    ccs_clk_switch #(
        .N        (4)
    ) u_cpu_sw (
        .i_ref_clk(i_ref_clk),
        .i_rst_n  (rst_sync_r),
        .i_src    (src_lvls),
        .i_sel    (cpu_sel),
        .o_clk    (o_cpu_clk),
        .o_cur    (cpu_cur)
    );

    // peripheral clock switch
    ccs_clk_switch #(
        .N        (4)
    ) u_per_sw (
        .i_ref_clk(i_ref_clk),
        .i_rst_n  (rst_sync_r),
        .i_src    (src_lvls),
        .i_sel    (per_sel),
        .o_clk    (o_periph_clk),
        .o_cur    (per_cur)
    );

    // registered oscillator controls, low-speed clocks and status
    always @(posedge i_ref_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            o_x1_osc_run              <= 1'b0;
            o_ext_main_accept         <= 1'b0;
            o_amp_gain_high           <= 1'b0;
            o_sub_xtal_run            <= 1'b0;
            o_ext_sub_accept          <= 1'b0;
            o_low_osc_run             <= 1'b1;  // R7
            o_wdt_clk                 <= 1'b0;
            o_tmh1_clk                <= 1'b0;
            o_cpu_on_sub_flag         <= 1'b0;
            o_main_source_status_flag <= 1'b0;
        end
        else
        begin
            o_x1_osc_run <= main_osc_enable_r && !main_osc_stop_r
                            && !main_external_input_select_r;
            o_ext_main_accept <= main_osc_enable_r && !main_osc_stop_r
                                 && main_external_input_select_r;
            o_amp_gain_high <= amplifier_gain_select_r;     // R16
            o_sub_xtal_run <= sub_osc_enable_r
                              && !sub_external_input_select_r; // R2 R4
            o_ext_sub_accept <= sub_osc_enable_r
                                && sub_external_input_select_r; // R2
            o_low_osc_run <= low_run;                       // R8 R9
            o_wdt_clk <= low_run && i_wdt_enable_opt
                         && i_low_osc_clk;                  // R7 R5
            o_tmh1_clk <= low_run && i_tmh1_low_sel
                          && i_low_osc_clk;                 // R5
            o_cpu_on_sub_flag <= (cpu_cur == `CCS_SRC_SUB); // R1
            o_main_source_status_flag <=
                (cpu_cur == `CCS_SRC_HI_SYS);               // R1
        end
    end

    // stop mode and peripheral source index are not needed further
    wire unused_ok;
    assign unused_ok = i_stop_mode & per_cur[0] & per_cur[1];

endmodule // ccs_clock_select

`default_nettype wire

// [test/ccs_clock_select_assertions.sv]
// Purpose: port-level checks for the clock select block
// Assumes: one clock domain, active-low reset
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none

module ccs_checker (
    // clock and reset
    input wire logic       i_ref_clk,
    input wire logic       i_nrst,
    // register port
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    // options and levels
    input wire logic       i_lowspeed_nostop_opt,
    input wire logic       i_wdt_enable_opt,
    input wire logic       i_tmh1_low_sel,
    input wire logic       i_stop_mode,
    input wire logic       i_low_osc_clk,
    // outputs watched
    input wire logic       o_x1_osc_run,
    input wire logic       o_ext_main_accept,
    input wire logic       o_sub_xtal_run,
    input wire logic       o_ext_sub_accept,
    input wire logic       o_low_osc_run,
    input wire logic       o_wdt_clk,
    input wire logic       o_tmh1_clk,
    input wire logic       o_cpu_on_sub_flag,
    input wire logic       o_main_source_status_flag
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    // status flags and oscillator controls
    a_flags_exclusive: assert property (
        !(o_cpu_on_sub_flag && o_main_source_status_flag))
        else $error("both status flags high");
    a_sub_one_mode: assert property (
        !(o_sub_xtal_run && o_ext_sub_accept))
        else $error("sub crystal and input both on");
    a_main_one_mode: assert property (
        !(o_x1_osc_run && o_ext_main_accept))
        else $error("x1 and external main both on");
    a_stop_keeps_sub: assert property (
        i_stop_mode && o_sub_xtal_run && !i_wr && !$past(i_wr)
        && !$past(i_wr, 2) |=> o_sub_xtal_run)
        else $error("sub oscillator halted in stop");
    a_main_needs_osc: assert property (
        $rose(o_main_source_status_flag)
        |-> $past(o_x1_osc_run) || $past(o_ext_main_accept))
        else $error("cpu on main clock with osc off");
    a_reset_state: assert property (
        $rose(i_nrst) |-> !o_cpu_on_sub_flag
        && !o_main_source_status_flag && o_low_osc_run)
        else $error("wrong state after reset");
    // low-speed clock consumers, low-speed osc option and idle read data
    a_wdt_from_low: assert property (
        o_wdt_clk |-> $past(i_wdt_enable_opt) && $past(i_low_osc_clk))
        else $error("watchdog clock without cause");
    a_tmh1_from_low: assert property (
        o_tmh1_clk |-> $past(i_tmh1_low_sel) && $past(i_low_osc_clk))
        else $error("timer clock without cause");
    a_nostop_keeps: assert property (
        i_lowspeed_nostop_opt [*3] |-> o_low_osc_run)
        else $error("low-speed osc stopped against option");
    a_rdata_idle: assert property (
        !$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");

    // main scenarios reached
    c_main_on: cover property ($rose(o_main_source_status_flag));
    c_sub_on: cover property ($rose(o_cpu_on_sub_flag));
    c_stop_sub: cover property (i_stop_mode && o_sub_xtal_run);
endmodule // ccs_checker

bind ccs_clock_select ccs_checker ccs_checker_inst (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_lowspeed_nostop_opt(i_lowspeed_nostop_opt),
    .i_wdt_enable_opt(i_wdt_enable_opt), .i_tmh1_low_sel(i_tmh1_low_sel),
    .i_stop_mode(i_stop_mode), .i_low_osc_clk(i_low_osc_clk),
    .o_x1_osc_run(o_x1_osc_run), .o_ext_main_accept(o_ext_main_accept),
    .o_sub_xtal_run(o_sub_xtal_run), .o_ext_sub_accept(o_ext_sub_accept),
    .o_low_osc_run(o_low_osc_run), .o_wdt_clk(o_wdt_clk),
    .o_tmh1_clk(o_tmh1_clk), .o_cpu_on_sub_flag(o_cpu_on_sub_flag),
    .o_main_source_status_flag(o_main_source_status_flag));

`default_nettype wire

// [test/tb_ccs_clock_select.sv]
// Purpose: self-checking bench for the clock select block
// Assumes: oscillator levels come from a counter on the ref clock
// Notes:   register table loop, then hand-written switch sequences
`timescale 1ns/1ps
`default_nettype none

module tb_ccs_clock_select;
    // inputs driven by the bench
    logic        i_ref_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic [7:0]  i_addr = 8'h00;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_lowspeed_nostop_opt = 1'b0;
    logic        i_wdt_enable_opt = 1'b1;
    logic        i_tmh1_low_sel = 1'b1;
    logic        i_stop_mode = 1'b0;
    logic        i_main_stab_done = 1'b1;
    logic [3:0]  cnt_r = 4'h0;
    // outputs and bookkeeping
    logic [7:0]  o_rdata;
    logic        o_x1_osc_run, o_ext_main_accept, o_amp_gain_high;
    logic        o_sub_xtal_run, o_ext_sub_accept, o_low_osc_run;
    logic        o_cpu_clk, o_periph_clk, o_wdt_clk, o_tmh1_clk;
    logic        o_cpu_on_sub_flag, o_main_source_status_flag;
    logic [24:0] rows [18];
    int          err_total = 0;
    int          num_checks = 0;
    // levels: hi, x1, ext main, sub xtal, ext sub, low-speed, none
    wire [6:0]   osc = {1'b0, cnt_r[1], ~cnt_r[3], cnt_r[3:0]};
    wire [7:0]   runs = {o_low_osc_run, o_amp_gain_high, 2'b00,
        o_x1_osc_run, o_ext_main_accept, o_sub_xtal_run, o_ext_sub_accept};
    wire [7:0]   flg = {6'h00, o_cpu_on_sub_flag, o_main_source_status_flag};

    ccs_clock_select ccs_clock_select_inst (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_lowspeed_nostop_opt(i_lowspeed_nostop_opt),
        .i_wdt_enable_opt(i_wdt_enable_opt), .i_tmh1_low_sel(i_tmh1_low_sel),
        .i_stop_mode(i_stop_mode), .i_main_stab_done(i_main_stab_done),
        .i_hi_osc_clk(osc[0]), .i_x1_clk(osc[1]), .i_ext_main_clk(osc[2]),
        .i_sub_xtal_clk(osc[3]), .i_ext_sub_clk(osc[4]),
        .i_low_osc_clk(osc[5]), .o_x1_osc_run(o_x1_osc_run),
        .o_ext_main_accept(o_ext_main_accept),
        .o_amp_gain_high(o_amp_gain_high), .o_sub_xtal_run(o_sub_xtal_run),
        .o_ext_sub_accept(o_ext_sub_accept), .o_low_osc_run(o_low_osc_run),
        .o_cpu_clk(o_cpu_clk), .o_periph_clk(o_periph_clk),
        .o_wdt_clk(o_wdt_clk), .o_tmh1_clk(o_tmh1_clk),
        .o_cpu_on_sub_flag(o_cpu_on_sub_flag),
        .o_main_source_status_flag(o_main_source_status_flag));

    // clock and oscillator pattern
    initial
    begin
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) cnt_r <= cnt_r + 4'h1;

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        @(posedge i_ref_clk);
        i_nrst <= 1'b0;
        repeat (12) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        #1;
    endtask

    // one-cycle write, then let the effect land
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        #1;
    endtask

    // one-cycle read, data checked in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask

    // let both switches settle, then switched clocks copy their source
    // one cycle late; every source pair is low together within 16 cycles
    task automatic follow(input int c, input int p, input int w);
        logic [6:0] v;
        repeat (16) @(negedge i_ref_clk);
        repeat (16)
        begin
            @(negedge i_ref_clk);
            v = osc;
            @(negedge i_ref_clk);
            chk({4'h0, o_cpu_clk, o_periph_clk, o_wdt_clk, o_tmh1_clk},
                {4'h0, v[c], v[p], v[w], v[w]});
        end
    endtask

    task automatic wait_flag(input logic s, input logic v);
        int n;
        n = 0;
        while ((s ? o_cpu_on_sub_flag : o_main_source_status_flag) !== v)
        begin
            @(negedge i_ref_clk);
            n++;
            if (n > 200)
            begin
                err_total++;
                conclude();
            end
        end
    endtask

    // hang guard
    initial
    begin
        repeat (30000) @(posedge i_ref_clk);
        err_total++;
        conclude();
    end

    // main sequence
    initial
    begin
        rows = '{25'h0_00_00_00, 25'h0_01_00_80, 25'h0_02_00_00,
            25'h0_03_00_00, 25'h0_04_00_00, 25'h0_05_00_01,
            25'h1_00_8f_81, 25'h1_00_70_70, 25'h1_00_00_00,
            25'h1_01_7f_00, 25'h1_01_ff_80, 25'h1_02_fa_00,
            25'h1_03_ef_00, 25'h1_04_fd_00, 25'h1_04_02_02,
            25'h1_04_00_00, 25'h1_05_fe_01, 25'h1_3c_ff_00};
        do_reset();
        chk(runs, 8'h80);
        chk(flg, 8'h00);
        follow(0, 0, 5);
        foreach (rows[i])
        begin
            if (rows[i][24])
                wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        $display("register table done");
        wr(8'h00, 8'h41);
        chk(runs, 8'hc0);
        wr(8'h01, 8'h00);
        chk(runs, 8'hc8);
        rd(8'h05, 8'h01);
        wr(8'h02, 8'h04);
        follow(0, 1, 5);
        wr(8'h02, 8'h05);
        wait_flag(1'b0, 1'b1);
        chk(flg, 8'h01);
        rd(8'h02, 8'h07);
        follow(1, 1, 5);
        wr(8'h02, 8'h00);
        wait_flag(1'b0, 1'b0);
        wr(8'h00, 8'hc0);
        chk(runs, 8'h84);
        wr(8'h02, 8'h05);
        wait_flag(1'b0, 1'b1);
        follow(2, 2, 5);
        $display("main clock test done");
        wr(8'h00, 8'hd0);
        chk(runs, 8'h86);
        wr(8'h03, 8'h10);
        wait_flag(1'b1, 1'b1);
        chk(flg, 8'h02);
        rd(8'h03, 8'h30);
        @(posedge i_ref_clk);
        i_stop_mode <= 1'b1;
        follow(3, 2, 5);
        chk(runs, 8'h86);
        @(posedge i_ref_clk);
        i_stop_mode <= 1'b0;
        wr(8'h03, 8'h00);
        wait_flag(1'b1, 1'b0);
        wait_flag(1'b0, 1'b1);
        chk(flg, 8'h01);
        wr(8'h00, 8'hc0);
        chk(runs, 8'h84);
        wr(8'h00, 8'hf0);
        chk(runs, 8'h85);
        wr(8'h02, 8'h00);
        wait_flag(1'b0, 1'b0);
        wr(8'h03, 8'h10);
        wait_flag(1'b1, 1'b1);
        follow(4, 0, 5);
        wr(8'h03, 8'h00);
        wait_flag(1'b1, 1'b0);
        follow(0, 0, 5);
        $display("subsystem test done");
        wr(8'h04, 8'h02);
        chk(runs, 8'h05);
        follow(0, 0, 6);
        wr(8'h04, 8'h00);
        chk(runs, 8'h85);
        follow(0, 0, 5);
        @(posedge i_ref_clk);
        i_lowspeed_nostop_opt <= 1'b1;
        do_reset();
        chk(flg, 8'h00);
        wr(8'h04, 8'h02);
        rd(8'h04, 8'h02);
        chk(runs, 8'h80);
        follow(0, 0, 5);
        @(posedge i_ref_clk);
        i_wdt_enable_opt <= 1'b0;
        i_tmh1_low_sel <= 1'b0;
        i_main_stab_done <= 1'b0;
        follow(0, 0, 6);
        rd(8'h05, 8'h00);
        $display("low-speed test done");
        conclude();
    end
endmodule // tb_ccs_clock_select

`default_nettype wire
